// ### dv/dtc_assertions.sv
// checker: register port and interrupt request relations of the dual timer
`timescale 1ns/1ps
module dtc_assertions (
   input wire logic clk,             // core clock
   input wire logic reset_n,         // async reset, active low
   input wire logic sfr_wr,          // write strobe
   input wire logic sfr_rd,          // read strobe
   input wire logic [7:0] sfr_addr,  // register address
   input wire logic [7:0] sfr_wdata, // write data
   input wire logic [7:0] sfr_rdata, // read data
   input wire logic sfr_hit,         // mapped read answer
   input wire logic vector_a_ack,    // vectoring pulse a
   input wire logic vector_b_ack,    // vectoring pulse b
   input wire logic irq_a,           // request a
   input wire logic irq_b            // request b
);
   logic mapped;
   logic ctl_wr;
   assign mapped = sfr_addr inside {8'h88, 8'h89, [8'h8A:8'h8D], [8'hCA:8'hCD]};
   assign ctl_wr = sfr_wr && sfr_addr == 8'h88;
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!reset_n);
   sequence s_rd;
      sfr_rd;
   endsequence
   sequence s_rd_gap;
      sfr_rd ##1 !sfr_rd;
   endsequence
   a_mapped_hit: assert property (s_rd ##0 mapped |=> sfr_hit)
      else $error("mapped read gave no hit");
   a_unmapped_read: assert property (s_rd ##0 !mapped |=> !sfr_hit && sfr_rdata == 8'h00)
      else $error("unmapped read answered");
   a_hit_origin: assert property (sfr_hit |-> $past(sfr_rd))
      else $error("hit without read");
   a_hit_one_cycle: assert property (s_rd_gap |=> !sfr_hit)
      else $error("hit held too long");
   a_rdata_holds: assert property (!$past(sfr_rd) |-> $stable(sfr_rdata))
      else $error("read data moved without read");
   a_ctl_flag_a: assert property (s_rd ##0 sfr_addr == 8'h88 |=> sfr_rdata[5] == $past(irq_a))
      else $error("flag a differs from request a");
   a_ctl_flag_b: assert property (s_rd ##0 sfr_addr == 8'h88 |=> sfr_rdata[7] == $past(irq_b))
      else $error("flag b differs from request b");
   a_irq_a_clear: assert property ($fell(irq_a) |-> $past(vector_a_ack) || $past(ctl_wr && !sfr_wdata[5]))
      else $error("request a dropped without cause");
   a_irq_b_clear: assert property ($fell(irq_b) |-> $past(vector_b_ack) || $past(ctl_wr && !sfr_wdata[7]))
      else $error("request b dropped without cause");
   a_irq_a_sticky: assert property (irq_a && !vector_a_ack && !ctl_wr |=> irq_a)
      else $error("request a not held");
   a_irq_b_sticky: assert property (irq_b && !vector_b_ack && !ctl_wr |=> irq_b)
      else $error("request b not held");
endmodule

// ### dv/dtc_pin_model.sv
// pin model: gate levels and falling-edge count pulses from outside
`timescale 1ns/1ps
module dtc_pin_model (
   input wire logic clk,    // core clock
   output logic [1:0] gate, // gate pins, b then a
   output logic [1:0] count // count pins, idle high
);
   initial begin
      gate = 2'b00;
      count = 2'b11;
   end
   task automatic set_gate(input int t, input logic lvl);
      @(negedge clk);
      gate[t] = lvl;
   endtask
   task automatic pulse(input int t, input int p);
      repeat (p) begin
         @(negedge clk);
         count[t] = 1'b0;
         repeat (3) @(negedge clk);
         count[t] = 1'b1;
         repeat (3) @(negedge clk);
      end
   endtask
endmodule

// ### dv/tb_top.sv
// testbench: register access, counting modes, gating, pin counting and flags
`timescale 1ns/1ps
module tb_top;
   localparam logic [7:0] ADDRS [12] = '{8'h88, 8'h89, 8'h8A, 8'h8B, 8'h8C, 8'h8D, 8'hCA, 8'hCB, 8'hCC, 8'hCD,
      8'h90, 8'h87};
   logic clk, reset_n, sfr_wr, sfr_rd, vector_a_ack, vector_b_ack, sfr_hit, irq_a, irq_b, h;
   logic [7:0] sfr_addr, sfr_wdata, sfr_rdata, d, v;
   logic [1:0] gate, count;
   int failures = 0;
   int comparisons = 0;
   int cycles = 0;
   dtc_pin_model pins (.clk(clk), .gate(gate), .count(count));
   dtc_top dut (.clk(clk), .reset_n(reset_n), .sfr_wr(sfr_wr), .sfr_rd(sfr_rd), .sfr_addr(sfr_addr),
      .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata), .sfr_hit(sfr_hit), .ext_irq_a_pin(gate[0]),
      .ext_irq_b_pin(gate[1]), .count_a_pin(count[0]), .count_b_pin(count[1]), .vector_a_ack(vector_a_ack),
      .vector_b_ack(vector_b_ack), .irq_a(irq_a), .irq_b(irq_b));
   initial begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end
   always @(posedge clk) begin
      cycles++;
      if (cycles == 20000) begin
         failures++;
         wrap_up();
      end
   end
   task automatic wrap_up();
      $display("comparisons %0d failures %0d", comparisons, failures);
      if (failures == 0 && comparisons > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask
   task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
      comparisons++;
      if (seen !== exp) begin
         failures++;
         $display("wrong value %s expected %h seen %h", name, exp, seen);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] val);
      @(negedge clk);
      sfr_wr = 1'b1;
      sfr_addr = a;
      sfr_wdata = val;
      @(negedge clk);
      sfr_wr = 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, output logic [7:0] val, output logic hit);
      @(negedge clk);
      sfr_rd = 1'b1;
      sfr_addr = a;
      @(negedge clk);
      sfr_rd = 1'b0;
      val = sfr_rdata;
      hit = sfr_hit;
   endtask
   task automatic reset_check();
      foreach (ADDRS[i]) begin
         rd(ADDRS[i], d, h);
         check("reset value", {7'h00, h, d}, {7'h00, i < 10, 8'h00});
      end
   endtask
   // expected {flag, high, low} after k count steps
   function automatic logic [16:0] model(input logic [1:0] m, input logic [7:0] hi, input logic [7:0] lo,
      input int k);
      logic ovf;
      logic [12:0] c13;
      ovf = 1'b0;
      for (int i = 0; i < k; i++) begin
         case (m)
            2'b00: begin
               c13 = {hi, lo[4:0]};
               ovf |= (c13 == 13'h1FFF);
               {hi, lo[4:0]} = c13 + 13'h0001;
            end
            2'b01: begin
               ovf |= ({hi, lo} == 16'hFFFF);
               {hi, lo} = {hi, lo} + 16'h0001;
            end
            2'b10: begin
               ovf |= (lo == 8'hFF);
               lo = (lo == 8'hFF) ? hi : lo + 8'h01;
            end
            default: ;
         endcase
      end
      return {ovf, hi, lo};
   endfunction
   task automatic trial(input int t, input logic [1:0] m, input logic g, input logic x, input int n);
      logic [7:0] lo, hi, rl, rh, c, mk, al, ah;
      logic [16:0] e;
      int k;
      al = t ? 8'h8B : 8'h8A;
      ah = t ? 8'h8D : 8'h8C;
      lo = 8'($urandom);
      if ($urandom % 2)
         lo[7:3] = 5'h1F;
      hi = ($urandom % 2) ? 8'hFF : 8'($urandom);
      mk = (m == 2'b00) ? 8'h1F : 8'hFF;
      wr(8'h88, 8'h00);
      wr(8'h89, 8'h33);
      wr(al, lo);
      wr(ah, hi);
      wr(8'h89, t ? {g, x, m, 4'h3} : {4'h3, g, x, m});
      wr(8'h88, t ? 8'h40 : 8'h10);
      if (x)
         pins.pulse(t, n);
      else
         repeat (n) @(negedge clk);
      wr(8'h89, 8'h33);
      k = x ? n : (g && !gate[t]) ? 0 : n + 2;
      e = model(m, hi, lo, k);
      repeat (3) @(negedge clk);
      rd(al, rl, h);
      rd(ah, rh, h);
      rd(8'h88, c, h);
      check("count", {rh, rl & mk}, {e[15:8], e[7:0] & mk});
      check("flag", {15'h0000, t ? c[7] : c[5]}, {15'h0000, e[16]});
      check("irq", {14'h0000, irq_b, irq_a}, t ? {14'h0000, e[16], 1'b0} : {15'h0000, e[16]});
      @(negedge clk);
      vector_a_ack = (t == 0);
      vector_b_ack = (t == 1);
      @(negedge clk);
      vector_a_ack = 1'b0;
      vector_b_ack = 1'b0;
      @(negedge clk);
      check("irq cleared", {14'h0000, irq_b, irq_a}, 16'h0000);
   endtask
   initial begin
      reset_n = 1'b0;
      sfr_wr = 1'b0;
      sfr_rd = 1'b0;
      sfr_addr = 8'h00;
      sfr_wdata = 8'h00;
      vector_a_ack = 1'b0;
      vector_b_ack = 1'b0;
      void'($urandom(44));
      repeat (20) @(posedge clk);
      @(negedge clk);
      reset_n = 1'b1;
      wr(8'h90, 8'hFF);
      reset_check();
      // control first with run bits clear, so no byte moves while read back
      for (int i = 0; i < 10; i++) begin
         v = (i == 0) ? 8'($urandom) & 8'hAF : 8'($urandom);
         wr(ADDRS[i], v);
         rd(ADDRS[i], d, h);
         check("stored", {8'h00, d}, {8'h00, v});
      end
      for (int r = 0; r < 6; r++)
         for (int m = 0; m < 4; m++)
            for (int t = 0; t < 2; t++)
               trial(t, 2'(m), 1'b0, 1'b0, 3 + $urandom % 20);
      for (int t = 0; t < 2; t++) begin
         pins.set_gate(t, 1'b0);
         trial(t, 2'b01, 1'b1, 1'b0, 8);
         pins.set_gate(t, 1'b1);
         repeat (4) @(negedge clk);
         trial(t, 2'b01, 1'b1, 1'b0, 8);
         trial(t, 2'b10, 1'b0, 1'b1, 3 + $urandom % 5);
      end
      // mid-run reset while timer a counts
      wr(8'h8A, 8'h5A);
      wr(8'h89, 8'h01);
      wr(8'h88, 8'h10);
      repeat (5) @(negedge clk);
      reset_n = 1'b0;
      repeat (3) @(negedge clk);
      reset_n = 1'b1;
      reset_check();
      wrap_up();
   end
endmodule
bind dtc_top dtc_assertions chk (.clk(clk), .reset_n(reset_n), .sfr_wr(sfr_wr), .sfr_rd(sfr_rd),
   .sfr_addr(sfr_addr), .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata), .sfr_hit(sfr_hit),
   .vector_a_ack(vector_a_ack), .vector_b_ack(vector_b_ack), .irq_a(irq_a), .irq_b(irq_b));

// ### hw/dtc_counter.sv
// one timer/counter channel: two data bytes, mode logic and overflow pulse
`timescale 1ns/1ps
module dtc_counter (
   input wire logic clk,              // core clock
   input wire logic reset_n,          // async reset, active low
   input dtc_pkg::dtc_cfg_t cfg,      // run, gate, source, mode
   input wire logic gate_level,       // synchronised gate pin level
   input wire logic ext_fall,         // falling edge on count pin
   input dtc_pkg::dtc_wr_t wr,        // software byte writes
   output logic [7:0] count_low,      // low data byte
   output logic [7:0] count_high,     // high data byte
   output logic overflow              // one-cycle overflow pulse
);
   logic [7:0] low_r;
   logic [7:0] high_r;
   logic tick;
   logic [7:0] low_nxt;
   logic [7:0] high_nxt;
   logic ovf_nxt;

   // count enable: run and (no gate or pin high); every core cycle, or each count pin fall when ext_sel, no prescaler
   assign tick = cfg.run & (~cfg.gate | gate_level) & (cfg.ext_sel ? ext_fall : 1'b1);

   always_comb begin
      low_nxt = low_r;
      high_nxt = high_r;
      ovf_nxt = 1'b0;
      if (tick) begin
         case (cfg.mode)
            dtc_pkg::DTC_MODE_13BIT: begin
               // 13 bits: high byte plus low five bits of low byte
               low_nxt = {low_r[7:5], low_r[4:0] + 5'h01};
               if (low_r[4:0] == dtc_pkg::LOW5_ONES) begin
                  high_nxt = high_r + 8'h01;
                  ovf_nxt = (high_r == dtc_pkg::BYTE_ONES);
               end
            end
            dtc_pkg::DTC_MODE_16BIT: begin
               low_nxt = low_r + 8'h01;
               if (low_r == dtc_pkg::BYTE_ONES) begin
                  high_nxt = high_r + 8'h01;
                  ovf_nxt = (high_r == dtc_pkg::BYTE_ONES);
               end
            end
            dtc_pkg::DTC_MODE_RELOAD: begin
               // count low byte only, reload from untouched high byte
               if (low_r == dtc_pkg::BYTE_ONES) begin
                  low_nxt = high_r;
                  ovf_nxt = 1'b1;
               end else begin
                  low_nxt = low_r + 8'h01;
               end
            end
            default: begin
               low_nxt = low_r;
            end
         endcase
      end
      if (wr.wr_low) begin
         low_nxt = wr.data;
      end
      if (wr.wr_high) begin
         high_nxt = wr.data;
      end
   end

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         low_r <= dtc_pkg::BYTE_ZERO;
         high_r <= dtc_pkg::BYTE_ZERO;
      end else begin
         low_r <= low_nxt;
         high_r <= high_nxt;
      end
   end

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         overflow <= 1'b0;
      end else begin
         overflow <= ovf_nxt;
      end
   end

   assign count_low = low_r;
   assign count_high = high_r;
endmodule

// ### hw/dtc_edge_sync.sv
// two-flop synchroniser with falling-edge detect for one pin
`timescale 1ns/1ps
module dtc_edge_sync (
   input wire logic clk,      // core clock
   input wire logic reset_n,  // async reset, active low
   input wire logic pin,      // asynchronous pin
   output logic level,        // synchronised level
   output logic fall          // one-cycle pulse on falling edge
);
   logic meta_r;
   logic sync_r;
   logic prev_r;

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         meta_r <= 1'b1;
         sync_r <= 1'b1;
         prev_r <= 1'b1;
      end else begin
         meta_r <= pin;
         sync_r <= meta_r;
         prev_r <= sync_r;
      end
   end

   assign level = sync_r;
   assign fall = prev_r & ~sync_r;
endmodule

// ### hw/dtc_pkg.sv
// package: register offsets, field positions and carrier types of the dual timer/counter
package dtc_pkg;
   localparam logic [7:0] ADDR_CONTROL = 8'h88;
   localparam logic [7:0] ADDR_MODE = 8'h89;
   localparam logic [7:0] ADDR_A_LOW = 8'h8A;
   localparam logic [7:0] ADDR_B_LOW = 8'h8B;
   localparam logic [7:0] ADDR_A_HIGH = 8'h8C;
   localparam logic [7:0] ADDR_B_HIGH = 8'h8D;
   localparam logic [7:0] ADDR_C_RELOAD_LOW = 8'hCA;
   localparam logic [7:0] ADDR_C_RELOAD_HIGH = 8'hCB;
   localparam logic [7:0] ADDR_C_LOW = 8'hCC;
   localparam logic [7:0] ADDR_C_HIGH = 8'hCD;
   // control register bit positions
   localparam int CTL_A_RUN = 4;
   localparam int CTL_A_OVF = 5;
   localparam int CTL_B_RUN = 6;
   localparam int CTL_B_OVF = 7;
   // mode register: timer a in low nibble, timer b in high nibble
   localparam int MODE_B_BASE = 4;
   localparam int MODE_SEL_LSB = 0;
   localparam int MODE_EXT_BIT = 2;
   localparam int MODE_GATE_BIT = 3;
   localparam logic [7:0] BYTE_ZERO = 8'h00;
   localparam logic [4:0] LOW5_ONES = 5'h1F;
   localparam logic [7:0] BYTE_ONES = 8'hFF;

   typedef enum logic [1:0] {
      DTC_MODE_13BIT = 2'b00,
      DTC_MODE_16BIT = 2'b01,
      DTC_MODE_RELOAD = 2'b10,
      DTC_MODE_HOLD = 2'b11
   } dtc_mode_t;

   typedef struct packed {
      logic run;
      logic gate;
      logic ext_sel;
      dtc_mode_t mode;
   } dtc_cfg_t;

   typedef struct packed {
      logic wr_low;
      logic wr_high;
      logic [7:0] data;
   } dtc_wr_t;
endpackage

// ### hw/dtc_top.sv
// dual timer/counter with special function register port
`timescale 1ns/1ps
module dtc_top (
   input wire logic clk,              // core clock, 40 MHz
   input wire logic reset_n,          // async reset, active low
   input wire logic sfr_wr,           // register write strobe
   input wire logic sfr_rd,           // register read strobe
   input wire logic [7:0] sfr_addr,   // register address
   input wire logic [7:0] sfr_wdata,  // write data
   output logic [7:0] sfr_rdata,      // read data, registered
   output logic sfr_hit,              // address maps here, registered
   input wire logic ext_irq_a_pin,    // gate pin for timer a
   input wire logic ext_irq_b_pin,    // gate pin for timer b
   input wire logic count_a_pin,      // count pin for timer a
   input wire logic count_b_pin,      // count pin for timer b
   input wire logic vector_a_ack,     // pulse: vectoring to timer a service
   input wire logic vector_b_ack,     // pulse: vectoring to timer b service
   output logic irq_a,                // timer a interrupt request
   output logic irq_b                 // timer b interrupt request
);
   //----------------------------------------
   // control and mode registers
   //----------------------------------------
   logic [7:0] control_r;
   logic [7:0] mode_r;
   logic [7:0] c_reload_low_r;
   logic [7:0] c_reload_high_r;
   logic [7:0] c_count_low_r;
   logic [7:0] c_count_high_r;
   logic [7:0] a_low;
   logic [7:0] a_high;
   logic [7:0] b_low;
   logic [7:0] b_high;
   logic a_ovf;
   logic b_ovf;
   logic gate_a_lvl;
   logic gate_b_lvl;
   logic cnt_a_fall;
   logic cnt_b_fall;
   logic wr_control;
   logic [7:0] rdata_nxt;
   logic hit_nxt;
   dtc_pkg::dtc_cfg_t cfg_a;
   dtc_pkg::dtc_cfg_t cfg_b;
   dtc_pkg::dtc_wr_t wr_a;
   dtc_pkg::dtc_wr_t wr_b;

   assign wr_control = sfr_wr && (sfr_addr == dtc_pkg::ADDR_CONTROL);

   // overflow flags: hardware set wins over software write or vector clear
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         control_r <= dtc_pkg::BYTE_ZERO;
      end else begin
         if (wr_control) begin
            control_r <= sfr_wdata;
         end
         if (vector_a_ack) begin
            control_r[dtc_pkg::CTL_A_OVF] <= 1'b0;
         end
         if (vector_b_ack) begin
            control_r[dtc_pkg::CTL_B_OVF] <= 1'b0;
         end
         if (a_ovf) begin
            control_r[dtc_pkg::CTL_A_OVF] <= 1'b1;
         end
         if (b_ovf) begin
            control_r[dtc_pkg::CTL_B_OVF] <= 1'b1;
         end
      end
   end

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         mode_r <= dtc_pkg::BYTE_ZERO;
      end else if (sfr_wr && (sfr_addr == dtc_pkg::ADDR_MODE)) begin
         mode_r <= sfr_wdata;
      end
   end

   //----------------------------------------
   // timer c plain data and reload registers
   //----------------------------------------
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         c_reload_low_r <= dtc_pkg::BYTE_ZERO;
         c_reload_high_r <= dtc_pkg::BYTE_ZERO;
         c_count_low_r <= dtc_pkg::BYTE_ZERO;
         c_count_high_r <= dtc_pkg::BYTE_ZERO;
      end else if (sfr_wr) begin
         if (sfr_addr == dtc_pkg::ADDR_C_RELOAD_LOW) begin
            c_reload_low_r <= sfr_wdata;
         end else if (sfr_addr == dtc_pkg::ADDR_C_RELOAD_HIGH) begin
            c_reload_high_r <= sfr_wdata;
         end else if (sfr_addr == dtc_pkg::ADDR_C_LOW) begin
            c_count_low_r <= sfr_wdata;
         end else if (sfr_addr == dtc_pkg::ADDR_C_HIGH) begin
            c_count_high_r <= sfr_wdata;
         end
      end
   end

   //----------------------------------------
   // channel configuration
   //----------------------------------------
   always_comb begin
      cfg_a.run = control_r[dtc_pkg::CTL_A_RUN];
      cfg_a.gate = mode_r[dtc_pkg::MODE_GATE_BIT];
      cfg_a.ext_sel = mode_r[dtc_pkg::MODE_EXT_BIT];
      cfg_a.mode = dtc_pkg::dtc_mode_t'(mode_r[dtc_pkg::MODE_SEL_LSB +: 2]);
      cfg_b.run = control_r[dtc_pkg::CTL_B_RUN];
      cfg_b.gate = mode_r[dtc_pkg::MODE_B_BASE + dtc_pkg::MODE_GATE_BIT];
      cfg_b.ext_sel = mode_r[dtc_pkg::MODE_B_BASE + dtc_pkg::MODE_EXT_BIT];
      cfg_b.mode = dtc_pkg::dtc_mode_t'(mode_r[dtc_pkg::MODE_B_BASE + dtc_pkg::MODE_SEL_LSB +: 2]);
      wr_a.data = sfr_wdata;
      wr_a.wr_low = sfr_wr && (sfr_addr == dtc_pkg::ADDR_A_LOW);
      wr_a.wr_high = sfr_wr && (sfr_addr == dtc_pkg::ADDR_A_HIGH);
      wr_b.data = sfr_wdata;
      wr_b.wr_low = sfr_wr && (sfr_addr == dtc_pkg::ADDR_B_LOW);
      wr_b.wr_high = sfr_wr && (sfr_addr == dtc_pkg::ADDR_B_HIGH);
   end

   //----------------------------------------
   // pin synchronisers
   //----------------------------------------
   dtc_edge_sync u_sync_gate_a (
      .clk(clk),
      .reset_n(reset_n),
      .pin(ext_irq_a_pin),
      .level(gate_a_lvl),
      .fall()
   );

   dtc_edge_sync u_sync_gate_b (
      .clk(clk),
      .reset_n(reset_n),
      .pin(ext_irq_b_pin),
      .level(gate_b_lvl),
      .fall()
   );

   dtc_edge_sync u_sync_cnt_a (
      .clk(clk),
      .reset_n(reset_n),
      .pin(count_a_pin),
      .level(),
      .fall(cnt_a_fall)
   );

   dtc_edge_sync u_sync_cnt_b (
      .clk(clk),
      .reset_n(reset_n),
      .pin(count_b_pin),
      .level(),
      .fall(cnt_b_fall)
   );

   //----------------------------------------
   // the two identical channels
   //----------------------------------------
   dtc_counter u_timer_a (
      .clk(clk),
      .reset_n(reset_n),
      .cfg(cfg_a),
      .gate_level(gate_a_lvl),
      .ext_fall(cnt_a_fall),
      .wr(wr_a),
      .count_low(a_low),
      .count_high(a_high),
      .overflow(a_ovf)
   );

   dtc_counter u_timer_b (
      .clk(clk),
      .reset_n(reset_n),
      .cfg(cfg_b),
      .gate_level(gate_b_lvl),
      .ext_fall(cnt_b_fall),
      .wr(wr_b),
      .count_low(b_low),
      .count_high(b_high),
      .overflow(b_ovf)
   );

   assign irq_a = control_r[dtc_pkg::CTL_A_OVF];
   assign irq_b = control_r[dtc_pkg::CTL_B_OVF];

   //----------------------------------------
   // read path
   //----------------------------------------
   always_comb begin
      rdata_nxt = dtc_pkg::BYTE_ZERO;
      hit_nxt = 1'b1;
      if (sfr_addr == dtc_pkg::ADDR_CONTROL) begin
         rdata_nxt = control_r;
      end else if (sfr_addr == dtc_pkg::ADDR_MODE) begin
         rdata_nxt = mode_r;
      end else if (sfr_addr == dtc_pkg::ADDR_A_LOW) begin
         rdata_nxt = a_low;
      end else if (sfr_addr == dtc_pkg::ADDR_B_LOW) begin
         rdata_nxt = b_low;
      end else if (sfr_addr == dtc_pkg::ADDR_A_HIGH) begin
         rdata_nxt = a_high;
      end else if (sfr_addr == dtc_pkg::ADDR_B_HIGH) begin
         rdata_nxt = b_high;
      end else if (sfr_addr == dtc_pkg::ADDR_C_RELOAD_LOW) begin
         rdata_nxt = c_reload_low_r;
      end else if (sfr_addr == dtc_pkg::ADDR_C_RELOAD_HIGH) begin
         rdata_nxt = c_reload_high_r;
      end else if (sfr_addr == dtc_pkg::ADDR_C_LOW) begin
         rdata_nxt = c_count_low_r;
      end else if (sfr_addr == dtc_pkg::ADDR_C_HIGH) begin
         rdata_nxt = c_count_high_r;
      end else begin
         hit_nxt = 1'b0;
      end
   end

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         sfr_rdata <= dtc_pkg::BYTE_ZERO;
         sfr_hit <= 1'b0;
      end else if (sfr_rd) begin
         sfr_rdata <= rdata_nxt;
         sfr_hit <= hit_nxt;
      end else begin
         sfr_hit <= 1'b0;
      end
   end
endmodule
